// ---- verilog/sar_readout_pkg.sv ----
// package for the successive-approximation converter serial readout control
// Functional notes
// - serial clock steps conversion and shifting; frame select starts and frames each transfer
// - frame select falling edge samples input, moves track to hold
// - serial output leaves high impedance when frame select falls
// - 13th rising serial clock edge returns hold to track, starting acquisition
// - output to high impedance after 16th falling edge or frame select rise
// - a full sample transfer spans sixteen serial clock cycles
// - device changes bits on falling edges, host captures on rising edges
// - word is three zeros, ten result bits msb first, three zeros
// - result is straight binary, step is reference over 1024
// - frame select low enters normal mode and starts a conversion
// - frame select rising between second and tenth falling edges enters shutdown
// - shutdown holds until frame select is next driven low
// - rise between 10th and 16th falling edges aborts but stays normal
// - rise before second falling edge keeps the current mode
package sar_readout_pkg;

  localparam int          RESULT_WIDTH     = 10;
  localparam int          COUNT_WIDTH      = 5;
  localparam logic [4:0]  TRACK_RISE_COUNT = 5'h0D;
  localparam logic [4:0]  LAST_FALL_COUNT  = 5'h10;
  localparam logic [4:0]  MODE_FALL_COUNT  = 5'h0A;
  localparam logic [4:0]  GUARD_FALL_COUNT = 5'h02;
  localparam logic [4:0]  LEAD_ZERO_COUNT  = 5'h03;
  localparam logic        RESET_SHUTDOWN   = 1'b0;

  typedef enum logic {MODE_NORMAL, MODE_SHUTDOWN} power_mode_type;

  typedef struct packed {
    logic out;
    logic oe;
  } serial_pin_type;

endpackage

// ---- verilog/sar_readout.sv ----
// frame sequencing and serial shifting of the converter result
`timescale 1ns/10ps
`default_nettype none
module sar_readout
  import sar_readout_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    frame_select_n,
  input  wire logic                    serial_clock,
  input  wire logic [RESULT_WIDTH-1:0] conversion_result,
  output logic                         serial_result_out,
  output logic                         serial_result_oe,
  output logic                         hold_state,
  output logic                         acquisition_interval,
  output logic                         shutdown_mode,
  output logic                         frame_aborted
);

  // pins from the host are asynchronous to clk, so two stages each
  logic [1:0]          cs_sync;
  logic [1:0]          sck_sync;
  logic                cs_prev;
  logic                sck_prev;
  logic [COUNT_WIDTH-1:0] rise_count;
  logic [COUNT_WIDTH-1:0] fall_count;
  logic [RESULT_WIDTH-1:0] held_result;
  serial_pin_type      pin;
  power_mode_type      mode;
  logic                hold;
  logic                acq;
  logic                abort;

  logic                next_cs_prev;
  logic                next_sck_prev;
  logic [COUNT_WIDTH-1:0] next_rise_count;
  logic [COUNT_WIDTH-1:0] next_fall_count;
  logic [RESULT_WIDTH-1:0] next_held_result;
  serial_pin_type      next_pin;
  power_mode_type      next_mode;
  logic                next_hold;
  logic                next_acq;
  logic                next_abort;

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  // bit presented after the given falling edge; zeros before and after the result
  function automatic logic word_bit(input logic [COUNT_WIDTH-1:0] n,
                                    input logic [RESULT_WIDTH-1:0] r);
    logic [COUNT_WIDTH-1:0] idx;
    idx = n - LEAD_ZERO_COUNT;
    if (n < LEAD_ZERO_COUNT || idx >= COUNT_WIDTH'(RESULT_WIDTH))
      word_bit = 1'b0;
    else
      word_bit = r[RESULT_WIDTH-1-idx];
    return word_bit;
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h0;
    end
    else
    begin
      cs_sync  <= {cs_sync[0], frame_select_n};
      sck_sync <= {sck_sync[0], serial_clock};
    end
  end

  assign cs_low   = ~cs_sync[1];
  assign cs_fall  = cs_prev & ~cs_sync[1];
  assign cs_rise  = ~cs_prev & cs_sync[1];
  assign sck_rise = ~sck_prev & sck_sync[1];
  assign sck_fall = sck_prev & ~sck_sync[1];

  always_comb
  begin
    next_cs_prev     = cs_sync[1];
    next_sck_prev    = sck_sync[1];
    next_rise_count  = rise_count;
    next_fall_count  = fall_count;
    next_held_result = held_result;
    next_pin         = pin;
    next_mode        = mode;
    next_hold        = hold;
    next_acq         = acq;
    next_abort       = 1'b0;
    if (!cs_low)
    begin
      next_rise_count = '0;
      next_fall_count = '0;
      next_pin.oe     = 1'b0;
      next_pin.out    = 1'b0;
      if (cs_rise)
      begin
        next_hold = 1'b0;
        // an early rise is treated as noise and leaves the mode alone
        if (fall_count >= GUARD_FALL_COUNT && fall_count < MODE_FALL_COUNT)
          next_mode = MODE_SHUTDOWN;
        if (fall_count >= GUARD_FALL_COUNT && fall_count < LAST_FALL_COUNT)
          next_abort = 1'b1;
      end
    end
    else if (cs_fall)
    begin
      next_mode        = MODE_NORMAL;
      next_hold        = 1'b1;
      next_acq         = 1'b0;
      next_held_result = conversion_result;
      next_pin.oe      = 1'b1;
      next_pin.out     = 1'b0;
    end
    else
    begin
      if (sck_rise && rise_count != '1)
      begin
        next_rise_count = rise_count + 1'b1;
        if (rise_count + 1'b1 == TRACK_RISE_COUNT)
        begin
          next_hold = 1'b0;
          next_acq  = 1'b1;
        end
      end
      if (sck_fall && fall_count != '1)
      begin
        next_fall_count = fall_count + 1'b1;
        next_pin.out = word_bit(fall_count + 1'b1, held_result);
        if (fall_count + 1'b1 >= LAST_FALL_COUNT)
          next_pin.oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_prev     <= 1'b1;
      sck_prev    <= 1'b0;
      rise_count  <= '0;
      fall_count  <= '0;
      held_result <= '0;
      pin         <= '0;
      mode        <= RESET_SHUTDOWN ? MODE_SHUTDOWN : MODE_NORMAL;
      hold        <= 1'b0;
      acq         <= 1'b0;
      abort       <= 1'b0;
    end
    else
    begin
      cs_prev     <= next_cs_prev;
      sck_prev    <= next_sck_prev;
      rise_count  <= next_rise_count;
      fall_count  <= next_fall_count;
      held_result <= next_held_result;
      pin         <= next_pin;
      mode        <= next_mode;
      hold        <= next_hold;
      acq         <= next_acq;
      abort       <= next_abort;
    end
  end

  assign serial_result_out    = pin.out;
  assign serial_result_oe     = pin.oe;
  assign hold_state           = hold;
  assign acquisition_interval = acq;
  assign shutdown_mode        = (mode == MODE_SHUTDOWN);
  assign frame_aborted        = abort;

endmodule
`default_nettype wire

// ---- tb/sar_readout_properties.sv ----
// port checker for the serial readout
`timescale 1ns/10ps
`default_nettype none
module sar_readout_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic frame_select_n,
  input wire logic serial_result_oe,
  input wire logic hold_state,
  input wire logic acquisition_interval,
  input wire logic shutdown_mode,
  input wire logic frame_aborted
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_start;
    $fell(frame_select_n);
  endsequence
  a_oe_on_start: assert property (s_start |-> ##[3:4] serial_result_oe) else $error("no oe");
  a_hold_on_start: assert property (s_start |-> ##[3:4] hold_state) else $error("no hold");
  a_normal_on_start: assert property (s_start |-> ##[3:4] !shutdown_mode) else $error("mode");
  a_oe_off_end: assert property ($rose(frame_select_n) |-> ##[3:4] !serial_result_oe) else $error("oe");
  a_track_acq: assert property ($rose(acquisition_interval) |-> $fell(hold_state)) else $error("acq");
  a_acq_tracks: assert property (acquisition_interval |-> !hold_state) else $error("track");
  a_shutdown_exit: assert property ($fell(shutdown_mode) |-> !frame_select_n) else $error("exit");
  a_abort_pulse: assert property (frame_aborted |-> frame_select_n ##1 !frame_aborted) else $error("abort");
endmodule
bind sar_readout sar_readout_properties i_props (.clk(clk), .resetn(resetn),
  .frame_select_n(frame_select_n), .serial_result_oe(serial_result_oe),
  .hold_state(hold_state), .acquisition_interval(acquisition_interval),
  .shutdown_mode(shutdown_mode), .frame_aborted(frame_aborted));
`default_nettype wire

// ---- tb/host_model.sv ----
// host side model: frame select, serial clock and bit capture
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  output logic     frame_select_n,
  output logic     serial_clock
);
  // clock low before select falls, so no extra leading zero appears
  initial {frame_select_n, serial_clock} = 2'b10;
  // n falls then deselect; clock stands low between frames
  task automatic frame(input int n, output logic [15:0] w);
    w = '0;
    frame_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 1; i <= n; i++)
    begin
      serial_clock <= 1'b1;
      repeat (i == 13 ? 8 : 4) @(posedge clk);
      // a released line shows the inverse of the last bit
      w = {w[14:0], serial_result_oe ? serial_result_out : ~w[0]};
      serial_clock <= 1'b0;
      repeat (4) @(posedge clk);
    end
    frame_select_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// bench: random words and frames cut short at listed and random counts
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sar_readout_pkg::*;
;
  logic                    clk = 1'b0;
  logic                    resetn = 1'b0;
  logic [RESULT_WIDTH-1:0] conversion_result = '0;
  logic                    frame_select_n, serial_clock, serial_result_out, serial_result_oe;
  logic                    hold_state, acquisition_interval, shutdown_mode, frame_aborted;
  int                      abort_cnt = 0;
  int                      abort_base = 0;
  logic [15:0]             w;
  int                      n;
  int                      lens[11] = '{16, 16, 1, 5, 16, 9, 10, 15, 16, 2, 16};
  int                      error_cnt = 0;
  int                      total_checks = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (frame_aborted === 1'b1) abort_cnt <= abort_cnt + 1;
  sar_readout i_dut (.clk(clk), .resetn(resetn), .frame_select_n(frame_select_n),
    .serial_clock(serial_clock), .conversion_result(conversion_result),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .hold_state(hold_state), .acquisition_interval(acquisition_interval),
    .shutdown_mode(shutdown_mode), .frame_aborted(frame_aborted));
  host_model i_host (.clk(clk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .frame_select_n(frame_select_n),
    .serial_clock(serial_clock));
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bits seen before each of the first k falls
  function automatic logic [15:0] exp_word(input logic [9:0] r, input int k);
    return {3'b000, r, 3'b000} >> (16 - k);
  endfunction
  // {shutdown, abort}; a deselect before the second fall keeps a normal mode
  function automatic logic [15:0] exp_flags(input int k);
    return {14'h0, k >= 2 && k <= 9, k >= 2 && k <= 15};
  endfunction
  initial
  begin
    #1000000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'hE29D));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 31; k++)
    begin
      n = k < 11 ? lens[k] : $urandom_range(16, 2);
      conversion_result <= k == 0 ? 10'h3FF : k == 1 ? 10'h000 : 10'($urandom);
      abort_base = abort_cnt;
      @(posedge clk);
      i_host.frame(n, w);
      // core not modelled, so even the word after shutdown is checked
      cmp(w, exp_word(conversion_result, n));
      cmp({14'h0, shutdown_mode, abort_cnt != abort_base}, exp_flags(n));
      cmp({14'h0, hold_state, acquisition_interval}, {15'h0, n >= 13});
    end
    stop_test();
  end
endmodule
`default_nettype wire
